/* design/eic_pkg.sv */
// Constants, register map and state codes of the edge interrupt controller.
// Assumes a 100 MHz system clock and an AHB-Lite master with 32-bit data.
// Overview of operation
// - A selected edge on a wakeup pin in wakeup mode sets its wakeup flag.
// - Wakeup flags survive acceptance; writing 0 clears, writing 1 changes nothing.
// - Wakeup edge select bit: 0 falling, 1 rising; register resets to zero.
// - Thirteen external sources: five request pins and eight wakeup pins.
// - Clearing the wakeup group enable blocks all eight wakeup requests.
// - All wakeup sources share vector 9; the handler finds the source.
// - Each request pin has its own edge bit; a detected edge sets its flag.
// - Each request pin has its own enable bit in the first enable register.
// - Request pins 4..0 use vectors 8..4; pin 0 highest priority.
// - Internal peripheral requests use both flag and enable registers, vectors 19..11.
// - An internal condition sets its flag only while its enable is 1.
// - The highest-priority set flag is selected; others stay pending.
// - Acceptance only while the global mask bit is 0; otherwise pending.
// - After the current instruction, program counter and condition codes are stacked.
// - Exception entry sets the global mask bit to 1.
// - After stacking the vector is read and the handler started.
// - A clear colliding with a request delays the exception past the clear.
// - Entry takes 4 stacking, 2 vector, 4 fetch and 4 internal states.
// - Word accesses force the address LSB to 0; stack accesses are words.
// - Condition codes stacked as a full word; return reloads the even byte only.
// - Wakeup mode bit going 0 to 1 while the pin is low sets its flag.
package eic_pkg;
    // Register byte addresses
    localparam logic [7:0] ADR_REQ_FIRST  = 8'h00;
    localparam logic [7:0] ADR_REQ_SECOND = 8'h04;
    localparam logic [7:0] ADR_EN_FIRST   = 8'h08;
    localparam logic [7:0] ADR_EN_SECOND  = 8'h0C;
    localparam logic [7:0] ADR_EXT_EDGE   = 8'h10;
    localparam logic [7:0] ADR_WAKE_FLAGS = 8'h14;
    localparam logic [7:0] ADR_WAKE_EDGE  = 8'h18;
    localparam logic [7:0] ADR_PORT_MODE  = 8'h1C;
    localparam logic [7:0] ADR_CCR        = 8'h20;
    localparam logic [7:0] ADR_STATUS     = 8'h24;
    // Field positions
    localparam int         WAKE_EN_BIT    = 5;
    localparam int         MASK_BIT       = 7;
    localparam logic [7:0] REQ1_FLAG_MASK = 8'hDF;
    localparam logic [7:0] REQ1_ONE_BITS  = 8'h20;
    localparam logic [7:0] REQ2_FLAG_MASK = 8'hDF;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    // Vector numbers
    localparam logic [4:0] VEC_EXT0       = 5'h04;
    localparam logic [4:0] VEC_WAKE       = 5'h09;
    localparam logic [4:0] VEC_TIMER_A    = 5'h0B;
    localparam logic [4:0] VEC_SECOND0    = 5'h0C;
    // Entry sequence lengths in clock states
    localparam logic [2:0] STACK_STATES   = 3'h4;
    localparam logic [2:0] VEC_STATES     = 3'h2;
    localparam logic [2:0] FETCH_STATES   = 3'h4;
    localparam logic [2:0] INTERNAL_STATES = 3'h4;
    // Entry sequencer states
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_WAIT  = 6'b000010,
        ST_STACK = 6'b000100,
        ST_VEC   = 6'b001000,
        ST_FETCH = 6'b010000,
        ST_INTL  = 6'b100000
    } eic_state_e;
endpackage

/* design/eic_top.sv */
// Edge interrupt controller: pin edge capture, flags, enables, priority,
// and exception entry sequencing toward the processor core.
// Assumes pins synchronous-ish inputs resampled here and a single AHB-Lite master.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module eic_top
    import eic_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // External pins, active low
    input  wire logic [7:0]  wake_pin_n,
    input  wire logic [4:0]  ext_pin_n,
    // Internal peripheral request pulses
    input  wire logic        timer_a_req,
    input  wire logic [7:0]  periph_req,
    // Core handshake
    input  wire logic        insn_done,
    input  wire logic [15:0] next_pc,
    input  wire logic [15:0] stack_ptr,
    input  wire logic [15:0] vec_data,
    input  wire logic        rte_load,
    input  wire logic [15:0] rte_word,
    output logic             stack_we,
    output logic      [15:0] stack_addr,
    output logic      [15:0] stack_wdata,
    output logic             vec_rd,
    output logic      [15:0] vec_addr,
    output logic             handler_go,
    output logic      [15:0] handler_addr,
    output logic             exc_busy
);
    import eic_pkg::*;

    // Registers
    logic [7:0]  req_first, req_second, en_first, en_second;
    logic [4:0]  ext_edge_sel;
    logic [7:0]  wake_request_flags, wake_edge_select, wake_mode;
    logic [4:0]  ext_mode;
    logic [7:0]  condition_code_reg;
    logic [7:0]  wake_s1, wake_s2, wake_prev;
    logic [4:0]  ext_s1, ext_s2, ext_prev;
    logic [7:0]  a_addr;
    logic        a_wr;
    logic [7:0]  rd_mux;
    eic_state_e  state;
    logic [2:0]  cnt;
    logic [4:0]  acc_vec;
    logic [15:0] sp_even;

    // Bus address phase decode and write strobes in the data phase
    wire         ap_valid = hsel & htrans[1] & hready;
    wire         w_req1   = a_wr & (a_addr == ADR_REQ_FIRST);
    wire         w_req2   = a_wr & (a_addr == ADR_REQ_SECOND);
    wire         w_en1    = a_wr & (a_addr == ADR_EN_FIRST);
    wire         w_en2    = a_wr & (a_addr == ADR_EN_SECOND);
    wire         w_eedge  = a_wr & (a_addr == ADR_EXT_EDGE);
    wire         w_wflag  = a_wr & (a_addr == ADR_WAKE_FLAGS);
    wire         w_wedge  = a_wr & (a_addr == ADR_WAKE_EDGE);
    wire         w_mode   = a_wr & (a_addr == ADR_PORT_MODE);
    wire         w_ccr    = a_wr & (a_addr == ADR_CCR);
    wire         clr_busy = w_req1 | w_req2 | w_en1 | w_en2 | w_wflag;

    // Edge detect on synchronised samples, selected polarity
    wire [7:0] wake_rise  = wake_s2 & ~wake_prev;
    wire [7:0] wake_fall  = ~wake_s2 & wake_prev;
    wire [7:0] wake_edge  = wake_mode &
                            ((wake_edge_select & wake_rise) |
                             (~wake_edge_select & wake_fall));
    wire [7:0] next_wmode = w_mode ? hwdata[15:8] : wake_mode;
    wire [7:0] wake_spur  = next_wmode & ~wake_mode & ~wake_s2;
    wire [7:0] wake_set   = wake_edge | wake_spur;
    wire [4:0] ext_rise   = ext_s2 & ~ext_prev;
    wire [4:0] ext_fall   = ~ext_s2 & ext_prev;
    wire [4:0] ext_set    = ext_mode &
                            ((ext_edge_sel & ext_rise) |
                             (~ext_edge_sel & ext_fall));

    // Flag next values: set wins over a write-zero clear
    wire [7:0] wclr_keep  = w_wflag ? hwdata[7:0] : 8'hFF;
    wire [7:0] next_wflag = (wake_request_flags & wclr_keep) | wake_set;
    wire [7:0] r1_keep    = w_req1 ? (hwdata[7:0] | ~REQ1_FLAG_MASK) : 8'hFF;
    wire [7:0] r1_set     = {timer_a_req & en_first[7], 2'b00, ext_set};
    wire [7:0] r1_rsv     = w_req1 ? {1'b0, hwdata[6], 6'h00}
                                   : {1'b0, req_first[6], 6'h00};
    wire [7:0] next_req1  = (((req_first & r1_keep) | r1_set) & REQ1_FLAG_MASK &
                             ~8'h40) | r1_rsv;
    wire [7:0] r2_keep    = w_req2 ? (hwdata[7:0] | ~REQ2_FLAG_MASK) : 8'hFF;
    wire [7:0] r2_set     = periph_req & en_second & REQ2_FLAG_MASK;
    wire [7:0] r2_rsv     = w_req2 ? (hwdata[7:0] & ~REQ2_FLAG_MASK)
                                   : (req_second & ~REQ2_FLAG_MASK);
    wire [7:0] next_req2  = (((req_second & r2_keep) | r2_set) & REQ2_FLAG_MASK) |
                            r2_rsv;

    // Enabled pending requests
    wire [4:0] ext_pend   = req_first[4:0] & en_first[4:0];
    wire       wake_pend  = (|wake_request_flags) & en_first[WAKE_EN_BIT];
    wire       ta_pend    = req_first[7] & en_first[7];
    wire [7:0] sec_pend   = req_second & en_second & REQ2_FLAG_MASK;
    wire       any_pend   = (|ext_pend) | wake_pend | ta_pend | (|sec_pend);

    // Priority select: lowest vector number wins
    logic [4:0] sel_vec;
    always_comb
    begin
        sel_vec = VEC_SECOND0;
        for (int i = 7; i >= 0; i--)
        begin
            if (sec_pend[i])
                sel_vec = VEC_SECOND0 + 5'(i);
        end
        if (ta_pend)
            sel_vec = VEC_TIMER_A;
        if (wake_pend)
            sel_vec = VEC_WAKE;
        for (int i = 4; i >= 0; i--)
        begin
            if (ext_pend[i])
                sel_vec = VEC_EXT0 + 5'(i);
        end
    end

    // Acceptance: mask clear, idle, and no clearing write this cycle
    wire accept = (state == ST_IDLE) & any_pend & ~condition_code_reg[MASK_BIT] & ~clr_busy;
    wire last   = (cnt == 3'h1);

    // Sequencer next state
    eic_state_e next_state;
    logic [2:0] next_cnt;
    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt == 3'h0) ? 3'h0 : cnt - 3'h1;
        case (state)
            ST_IDLE:
                if (accept)
                    next_state = ST_WAIT;
            ST_WAIT:
                if (insn_done)
                begin
                    next_state = ST_STACK;
                    next_cnt   = STACK_STATES;
                end
            ST_STACK:
                if (last)
                begin
                    next_state = ST_VEC;
                    next_cnt   = VEC_STATES;
                end
            ST_VEC:
                if (last)
                begin
                    next_state = ST_FETCH;
                    next_cnt   = FETCH_STATES;
                end
            ST_FETCH:
                if (last)
                begin
                    next_state = ST_INTL;
                    next_cnt   = INTERNAL_STATES;
                end
            ST_INTL:
                if (last)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // Condition code register: entry sets mask, return reloads even byte
    wire [7:0] next_ccr = (state == ST_WAIT && insn_done) ? (condition_code_reg | 8'h80)
                        : rte_load ? rte_word[15:8]
                        : w_ccr    ? hwdata[7:0] : condition_code_reg;

    // Stack address of the current push, LSB forced low
    wire [15:0] push_addr = (cnt == STACK_STATES) ? (sp_even - 16'h0002)
                                                  : (sp_even - 16'h0004);
    wire        push_now  = (state == ST_STACK) &&
                            (cnt == STACK_STATES || cnt == 3'h2);
    wire [15:0] push_data = (cnt == STACK_STATES) ? next_pc : {condition_code_reg, condition_code_reg};

    // Read data mux for the address phase
    always_comb
    begin
        case (haddr[7:0])
            ADR_REQ_FIRST:  rd_mux = req_first;
            ADR_REQ_SECOND: rd_mux = req_second;
            ADR_EN_FIRST:   rd_mux = en_first;
            ADR_EN_SECOND:  rd_mux = en_second;
            ADR_EXT_EDGE:   rd_mux = {3'h0, ext_edge_sel};
            ADR_WAKE_FLAGS: rd_mux = wake_request_flags;
            ADR_WAKE_EDGE:  rd_mux = wake_edge_select;
            ADR_CCR:        rd_mux = condition_code_reg;
            ADR_STATUS:     rd_mux = {exc_busy, 2'h0, acc_vec};
            default:        rd_mux = RESET_BYTE;
        endcase
    end

    // Bus slave registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_addr    <= 8'h00;
            a_wr      <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            a_addr    <= haddr[7:0];
            a_wr      <= ap_valid & hwrite & (haddr[31:8] == 24'h00_0000);
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_valid && !hwrite)
                hrdata <= (haddr[7:0] == ADR_PORT_MODE) ? {16'h0000, wake_mode, 3'h0,
                          ext_mode} : {24'h00_0000,
                          (haddr[31:8] == 24'h00_0000) ? rd_mux : RESET_BYTE};
        end
    end

    // Pin synchronisers and previous samples
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_s1 <= 8'hFF;
            wake_s2 <= 8'hFF;
            wake_prev <= 8'hFF;
            ext_s1  <= 5'h1F;
            ext_s2  <= 5'h1F;
            ext_prev <= 5'h1F;
        end
        else
        begin
            wake_s1 <= wake_pin_n;
            wake_s2 <= wake_s1;
            wake_prev <= wake_s2;
            ext_s1  <= ext_pin_n;
            ext_s2  <= ext_s1;
            ext_prev <= ext_s2;
        end
    end

    // Software registers and flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_first          <= REQ1_ONE_BITS;
            req_second         <= RESET_BYTE;
            en_first           <= RESET_BYTE;
            en_second          <= RESET_BYTE;
            ext_edge_sel       <= 5'h00;
            wake_request_flags <= RESET_BYTE;
            wake_edge_select   <= RESET_BYTE;
            wake_mode          <= RESET_BYTE;
            ext_mode           <= 5'h00;
            condition_code_reg                <= RESET_BYTE;
        end
        else
        begin
            req_first          <= next_req1 | REQ1_ONE_BITS;
            req_second         <= next_req2;
            wake_request_flags <= next_wflag;
            wake_mode          <= next_wmode;
            condition_code_reg                <= next_ccr;
            if (w_en1)
                en_first <= hwdata[7:0];
            if (w_en2)
                en_second <= hwdata[7:0];
            if (w_eedge)
                ext_edge_sel <= hwdata[4:0];
            if (w_wedge)
                wake_edge_select <= hwdata[7:0];
            if (w_mode)
                ext_mode <= hwdata[4:0];
        end
    end

    // Exception entry sequencer and core-facing outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state        <= ST_IDLE;
            cnt          <= 3'h0;
            acc_vec      <= 5'h00;
            sp_even      <= 16'h0000;
            stack_we     <= 1'b0;
            stack_addr   <= 16'h0000;
            stack_wdata  <= 16'h0000;
            vec_rd       <= 1'b0;
            vec_addr     <= 16'h0000;
            handler_go   <= 1'b0;
            handler_addr <= 16'h0000;
            exc_busy     <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            cnt        <= next_cnt;
            exc_busy   <= (next_state != ST_IDLE);
            stack_we   <= push_now;
            stack_addr <= push_addr;
            stack_wdata <= push_data;
            vec_rd     <= (state == ST_VEC) && (cnt == VEC_STATES);
            vec_addr   <= {10'h000, acc_vec, 1'b0};
            handler_go <= (state == ST_INTL) && last;
            if (accept)
                acc_vec <= sel_vec;
            if (state == ST_WAIT && insn_done)
                sp_even <= {stack_ptr[15:1], 1'b0};
            if (state == ST_VEC && last)
                handler_addr <= {vec_data[15:1], 1'b0};
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_mask_blocks_accept: assert property (condition_code_reg[MASK_BIT] |-> !accept)
        else $error("Request accepted while masked");
    chk_entry_sets_mask: assert property (
        state == ST_WAIT && insn_done |=> condition_code_reg[MASK_BIT])
        else $error("Mask not set at entry");
    chk_entry_length: assert property (
        state == ST_WAIT && insn_done |=> ##14 handler_go)
        else $error("Entry length wrong");
    chk_wake_group_gate: assert property (
        !en_first[WAKE_EN_BIT] && ext_pend == 5'h00 && !ta_pend && sec_pend == 8'h00
        |-> !accept)
        else $error("Wakeup request recognised while disabled");
    chk_flag_survives: assert property (
        wake_request_flags[0] && !(w_wflag && !hwdata[0]) |=> wake_request_flags[0])
        else $error("Wakeup flag lost");
    chk_wake_edge_sets: assert property (
        wake_edge[0] |=> wake_request_flags[0])
        else $error("Wakeup edge not flagged");
    chk_ext0_first: assert property (
        accept && ext_pend[0] |=> acc_vec == VEC_EXT0)
        else $error("Pin 0 not highest priority");
    chk_clear_defers: assert property (clr_busy && state == ST_IDLE |=> !exc_busy)
        else $error("Accepted during clearing write");
    chk_stack_even: assert property (stack_we |-> !stack_addr[0])
        else $error("Odd stack address");
    chk_spur_flag: assert property (
        wake_spur[4] |=> wake_request_flags[4])
        else $error("Mode switch flag missing");

    cov_wake_accept: cover property (accept && sel_vec == VEC_WAKE);
    cov_handler: cover property (handler_go);
    cov_set_and_clear: cover property (w_wflag && |wake_set);
endmodule

/* bench/eic_core_model.sv */
// Behavioural processor core facing the controller's exception entry.
// Assumes one controller; the bench picks the stall length and vector word.
`timescale 1ns/1ps
module eic_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Bench controls
    input  wire logic [3:0]  busy_delay,
    input  wire logic [15:0] handler_word,
    // Controller handshake
    input  wire logic        exc_busy,
    input  wire logic        vec_rd,
    output logic             insn_done,
    output logic      [15:0] next_pc,
    output logic      [15:0] stack_ptr,
    output logic      [15:0] vec_data,
    output logic             rte_load,
    output logic      [15:0] rte_word
);
    int wait_cnt;
    // Resume address and an even stack pointer
    assign next_pc   = 16'h1234;
    assign stack_ptr = 16'hFF80;
    initial
    begin
        rte_load = 1'b0;
        rte_word = 16'h0000;
    end
    // Vector word answers the read strobe in the same cycle; the inverse shows otherwise
    assign vec_data = vec_rd ? handler_word : ~handler_word;
    // Finish the running instruction after the chosen stall
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            insn_done <= 1'b0;
            wait_cnt  <= 0;
        end
        else
        begin
            insn_done <= 1'b0;
            if (!exc_busy)
                wait_cnt <= 0;
            else if (wait_cnt < busy_delay)
                wait_cnt <= wait_cnt + 1;
            else if (wait_cnt == busy_delay)
            begin
                insn_done <= 1'b1;
                wait_cnt  <= 99;
            end
        end
    end
    // Return from exception with a word whose odd byte must be ignored
    task automatic do_return(input logic [15:0] w);
        rte_load <= 1'b1;
        rte_word <= w;
        @(posedge clk);
        rte_load <= 1'b0;
        rte_word <= ~w;
        @(posedge clk);
    endtask
endmodule

/* bench/edge_interrupt_controller_test.sv */
// Self-checking bench for the edge interrupt controller.
// Assumes the core model beside it and a single AHB-Lite master here.
`timescale 1ns/1ps
module edge_interrupt_controller_test;
    import eic_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, timer_a_req = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, seed = 32'hD3FF868F, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [7:0] wake_pin_n = 8'hFF, periph_req = 8'h00;
    logic [4:0] ext_pin_n = 5'h1F;
    logic [3:0] busy_delay = 4'h1;
    logic [15:0] handler_word = '0, next_pc, stack_ptr, vec_data, rte_word, stack_addr;
    logic [15:0] stack_wdata, vec_addr, handler_addr, vaddr;
    logic hreadyout, hresp, insn_done, rte_load, stack_we, vec_rd, handler_go, exc_busy;
    logic [15:0] stk_a[$], stk_d[$];
    int error_cnt, num_checks, cyc = 0, stk_t, go_t;
    always #5 clk = ~clk;
    eic_top i_eic_top (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_pin_n(wake_pin_n),
        .ext_pin_n(ext_pin_n), .timer_a_req(timer_a_req), .periph_req(periph_req),
        .insn_done(insn_done), .next_pc(next_pc), .stack_ptr(stack_ptr),
        .vec_data(vec_data), .rte_load(rte_load), .rte_word(rte_word),
        .stack_we(stack_we), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
        .vec_rd(vec_rd), .vec_addr(vec_addr), .handler_go(handler_go),
        .handler_addr(handler_addr), .exc_busy(exc_busy));
    eic_core_model i_eic_core_model (.clk(clk), .rst_n(rst_n), .busy_delay(busy_delay),
        .handler_word(handler_word), .exc_busy(exc_busy), .vec_rd(vec_rd),
        .insn_done(insn_done), .next_pc(next_pc), .stack_ptr(stack_ptr),
        .vec_data(vec_data), .rte_load(rte_load), .rte_word(rte_word));
    // Record stack pushes and the vector address seen during entry
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (vec_rd === 1'b1)
            vaddr <= vec_addr;
        if (stack_we === 1'b1)
        begin
            if (stk_a.size() == 0)
                stk_t = cyc;
            stk_a.push_back(stack_addr);
            stk_d.push_back(stack_wdata);
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Wait for hready at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            close_out();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check(hresp, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    // One exception entry: vector, stacking, timing, mask; then clear flags
    task automatic run_entry(input int vec, input logic [11:0] fa, input logic [31:0] ef,
                             input logic [31:0] fd);
        int n;
        seed = lfsr(seed);
        handler_word <= seed[15:0];
        busy_delay <= 4'(seed[19:16] % 13);
        stk_a.delete();
        stk_d.delete();
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (handler_go !== 1'b1 && n < 300);
        go_t = cyc;
        if (n >= 300)
        begin
            error_cnt++;
            close_out();
        end
        check(vaddr, 32'(vec * 2));
        check(handler_addr, {16'h0, handler_word & 16'hFFFE});
        check({stk_a[0], stk_d[0]}, 32'hFF7E1234);
        check({stk_a[1], stk_d[1]}, 32'hFF7C8080);
        check(stk_a.size(), 32'h2);
        // First push shows one cycle into stacking, so one state less than the entry
        check(go_t - stk_t, 32'(4 + 2 + 4 + 4 - 1));
        rd(ADR_CCR, 32'h80);
        rd(fa, ef);
        wr(fa, fd);
    endtask
    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        idle(16);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(ADR_WAKE_FLAGS, 32'h0);
        rd(ADR_WAKE_EDGE, 32'h0);
        rd(ADR_REQ_FIRST, 32'h20);
        rd(12'h100, 32'h0);
        wake_pin_n[4] <= 1'b0;
        idle(6);
        wr(ADR_PORT_MODE, 32'hFF00);
        idle(6);
        rd(ADR_WAKE_FLAGS, 32'h10);
        wr(ADR_WAKE_FLAGS, 32'h0);
        wake_pin_n[4] <= 1'b1;
        wr(ADR_WAKE_EDGE, 32'h01);
        wake_pin_n[1:0] <= 2'b00;
        idle(6);
        rd(ADR_WAKE_FLAGS, 32'h02);
        wake_pin_n[0] <= 1'b1;
        idle(6);
        wr(ADR_WAKE_FLAGS, 32'hFF);
        rd(ADR_WAKE_FLAGS, 32'h03);
        check(exc_busy, 32'h0);
        wr(ADR_EN_FIRST, 32'h20);
        run_entry(9, ADR_WAKE_FLAGS, 32'h03, 32'h0);
        i_eic_core_model.do_return(16'h00FF);
        rd(ADR_CCR, 32'h0);
        wr(ADR_CCR, 32'h80);
        seed = lfsr(seed);
        timer_a_req <= 1'b1;
        periph_req <= seed[7:0];
        idle(1);
        timer_a_req <= 1'b0;
        periph_req <= 8'h00;
        idle(2);
        rd(ADR_REQ_FIRST, 32'h20);
        rd(ADR_REQ_SECOND, 32'h0);
        wr(ADR_EN_FIRST, 32'h9F);
        timer_a_req <= 1'b1;
        idle(1);
        timer_a_req <= 1'b0;
        idle(2);
        rd(ADR_REQ_FIRST, 32'hA0);
        wr(ADR_REQ_FIRST, 32'h0);
        wr(ADR_PORT_MODE, 32'hFF1F);
        wr(ADR_EXT_EDGE, 32'h0);
        ext_pin_n <= 5'h16;
        idle(6);
        rd(ADR_REQ_FIRST, 32'h29);
        idle(8);
        check(exc_busy, 32'h0);
        wr(ADR_CCR, 32'h0);
        run_entry(4, ADR_REQ_FIRST, 32'h29, 32'hBE);
        i_eic_core_model.do_return(16'h00FF);
        run_entry(7, ADR_REQ_FIRST, 32'h28, 32'h0);
        i_eic_core_model.do_return(16'h00FF);
        rd(ADR_CCR, 32'h0);
        close_out();
    end
endmodule
